// >>> acsc_defines.vh
// acsc_defines.vh: constants for the converter serial channel control block
// assumes inclusion by bare name from the design files
`ifndef ACSC_DEFINES_VH
`define ACSC_DEFINES_VH

// ----------------------------------------------------------------
// control byte layout
// ----------------------------------------------------------------
`define ACSC_CTRL_BITS        4'd8
`define ACSC_CHAN_MSB         5
`define ACSC_CHAN_LSB         3
`define ACSC_CHAN_RESET       3'h0

// ----------------------------------------------------------------
// frame timing, in serial clock cycles
// ----------------------------------------------------------------
`define ACSC_CONV_CYCLES      5'd16
`define ACSC_TRACK_CYCLES     5'd3
`define ACSC_LEAD_ZEROS       5'd4
`define ACSC_RESULT_LAST      5'd12
`define ACSC_RESULT_BITS      8

`endif

// >>> acsc_pin_sync.v
// acsc_pin_sync.v: two-flop synchroniser for a group of pin inputs
// assumes asynchronous active-high reset and pins outside the clock domain
module acsc_pin_sync #(
    parameter            WIDTH = 3,
    parameter [WIDTH-1:0] RESET = {WIDTH{1'b0}}
) (
    input  wire             core_clk_in,
    input  wire             sys_rst_in,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_q <= RESET;
            sync_q <= RESET;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // acsc_pin_sync

// >>> acsc_sar.v
// acsc_sar.v: successive-approximation sequencer, one decision in each of the first eight hold cycles
// assumes the comparator input is settled and synchronous to core_clk_in
`include "acsc_defines.vh"
module acsc_sar (
    input  wire       core_clk_in,
    input  wire       sys_rst_in,
    input  wire       start_in,
    input  wire       step_in,
    input  wire       comp_high_in,
    output reg  [7:0] dac_code_out,
    output reg  [7:0] result_out
);
    reg [7:0] trial_q;
    reg [7:0] bit_q;

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            trial_q      <= 8'h00;
            bit_q        <= 8'h00;
            dac_code_out <= 8'h00;
            result_out   <= 8'h00;
        end else if (start_in) begin
            trial_q      <= 8'h80;
            bit_q        <= 8'h80;
            dac_code_out <= 8'h80;
        end else if (step_in && bit_q != 8'h00) begin
            // keep the bit when the input is above the trial level
            if (comp_high_in) begin
                trial_q      <= trial_q | (bit_q >> 1);
                dac_code_out <= trial_q | (bit_q >> 1);
                if (bit_q == 8'h01)
                    result_out <= trial_q;
            end else begin
                trial_q      <= (trial_q & ~bit_q) | (bit_q >> 1);
                dac_code_out <= (trial_q & ~bit_q) | (bit_q >> 1);
                if (bit_q == 8'h01)
                    result_out <= trial_q & ~bit_q;
            end
            bit_q <= bit_q >> 1;
        end
    end
endmodule // acsc_sar

// >>> acsc_serial_ctrl.v
// acsc_serial_ctrl.v: serial control of an eight-channel 8-bit converter
// assumes chip select, serial clock and data in come from a host off-domain
//
// Overview of operation
// - control byte sampled on first eight rises
// - new channel applies to next conversion
// - bits 7, 6, 2, 1, 0 ignored
// - bits 5..3 select input zero..seven
// - channel resets to input zero
// - first conversion valid, no dummy needed
// - result is 8-bit straight binary
// - powered from 1st to 16th fall while select low, down otherwise
// - power-down between 16th and next 1st fall
// - sixteen cycles per conversion, back to back
// - simultaneous select and clock fall tracks
// - data out released, clock gated when deselected
// - four zeros, result msb first, four zeros
// - track three cycles, hold thirteen
`include "acsc_defines.vh"
module acsc_serial_ctrl (
    input  wire       core_clk_in,
    input  wire       sys_rst_in,
    input  wire       cs_n_in,
    input  wire       sclk_in,
    input  wire       din_in,
    input  wire       comp_high_in,
    output reg        dout_out,
    output reg        dout_oe_out,
    output reg  [2:0] mux_sel_out,
    output reg        track_out,
    output reg        power_up_out,
    output reg  [7:0] dac_code_out,
    output reg  [7:0] result_out
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_TRACK = 3'b010;
    localparam [2:0] ST_HOLD  = 3'b100;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [2:0] chan_field;
        input [7:0] ctrl;
        begin
            chan_field = ctrl[`ACSC_CHAN_MSB:`ACSC_CHAN_LSB];
        end
    endfunction

    function [4:0] cyc_inc;
        input [4:0] cyc;
        begin
            if (cyc == `ACSC_CONV_CYCLES)
                cyc_inc = 5'd1;
            else
                cyc_inc = cyc + 5'd1;
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    wire [2:0] pins_s;
    reg        cs_n_q;
    reg        sclk_q;

    acsc_pin_sync #(
        .WIDTH (3),
        .RESET (3'b011)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .pin_in      ({cs_n_in, sclk_in, din_in}),
        .sync_out    (pins_s)
    );

    wire cs_n_s   = pins_s[2];
    wire sclk_s   = pins_s[1];
    wire din_s    = pins_s[0];
    wire cs_fall  = cs_n_q & ~cs_n_s;
    // clock gated off while deselected
    wire sck_rise = ~cs_n_s & ~sclk_q & sclk_s;
    wire sck_fall = ~cs_n_s & sclk_q & ~sclk_s;

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b1;
        end else begin
            cs_n_q <= cs_n_s;
            sclk_q <= sclk_s;
        end
    end

    // ----------------------------------------------------------------
    // frame sequencing
    // ----------------------------------------------------------------
    reg  [2:0] state_q;
    reg  [4:0] fall_cnt_q;   // falling edges seen in this conversion
    reg  [3:0] rise_cnt_q;   // rising edges seen in this conversion
    reg  [7:0] shift_q;
    reg  [2:0] chan_q;
    reg        sar_start_q;
    wire [7:0] sar_dac;
    wire [7:0] sar_result;

    // select falling with clock low counts as the first falling edge
    wire first_fall = cs_fall & ~sclk_s;
    wire any_fall   = sck_fall | first_fall;
    wire [4:0] fall_next = cyc_inc(fall_cnt_q);

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q     <= ST_IDLE;
            fall_cnt_q  <= 5'd0;
            rise_cnt_q  <= 4'd0;
            shift_q     <= 8'h00;
            chan_q      <= `ACSC_CHAN_RESET;
            mux_sel_out <= `ACSC_CHAN_RESET;
            sar_start_q <= 1'b0;
        end else begin
            sar_start_q <= 1'b0;
            if (cs_n_s) begin
                // partial byte discarded, stored channel kept
                state_q    <= ST_IDLE;
                fall_cnt_q <= 5'd0;
                rise_cnt_q <= 4'd0;
            end else begin
                if (cs_fall) begin
                    rise_cnt_q <= 4'd0;
                    // mux follows the byte of the previous conversion
                    mux_sel_out <= chan_q;
                end
                if (any_fall) begin
                    fall_cnt_q <= fall_next;
                    case (fall_next)
                        5'd1: begin
                            state_q     <= ST_TRACK;
                            mux_sel_out <= chan_q;
                        end
                        `ACSC_LEAD_ZEROS: begin
                            state_q     <= ST_HOLD;
                            sar_start_q <= 1'b1;
                        end
                        default: state_q <= state_q;
                    endcase
                end
                if (sck_rise) begin
                    if (rise_cnt_q < `ACSC_CTRL_BITS)
                        shift_q <= {shift_q[6:0], din_s};
                    if (rise_cnt_q == `ACSC_CTRL_BITS - 4'd1)
                        chan_q <= chan_field({shift_q[6:0], din_s});
                    if (rise_cnt_q == 4'd15)
                        rise_cnt_q <= 4'd0;
                    else
                        rise_cnt_q <= rise_cnt_q + 4'd1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // converter core
    // ----------------------------------------------------------------
    acsc_sar u_sar (
        .core_clk_in  (core_clk_in),
        .sys_rst_in   (sys_rst_in),
        .start_in     (sar_start_q),
        .step_in      (sck_fall & (state_q == ST_HOLD)),
        .comp_high_in (comp_high_in),
        .dac_code_out (sar_dac),
        .result_out   (sar_result)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dout_out     <= 1'b0;
            dout_oe_out  <= 1'b0;
            track_out    <= 1'b0;
            power_up_out <= 1'b0;
            dac_code_out <= 8'h00;
            result_out   <= 8'h00;
        end else begin
            dout_oe_out  <= ~cs_n_s;
            track_out    <= ~cs_n_s & (state_q == ST_TRACK);
            // down when deselected or between conversions
            power_up_out <= ~cs_n_s & (state_q != ST_IDLE) &
                            ~(fall_cnt_q == `ACSC_CONV_CYCLES);
            dac_code_out <= sar_dac;
            result_out   <= sar_result;
            if (cs_n_s) begin
                dout_out <= 1'b0;
            end else if (any_fall) begin
                if (fall_next > `ACSC_LEAD_ZEROS &&
                    fall_next <= `ACSC_RESULT_LAST) begin
                    // bit decided by this step, msb first
                    dout_out <= comp_high_in;
                end else begin
                    dout_out <= 1'b0;
                end
            end
        end
    end
endmodule // acsc_serial_ctrl

// >>> acsc_serial_ctrl_sva.sv
// acsc_serial_ctrl_sva.sv: port checker for the serial control block
// assumes bind onto acsc_serial_ctrl and sclk half periods of 3+ core cycles
module acsc_serial_ctrl_chk (
    input wire logic       core_clk_in,
    input wire logic       sys_rst_in,
    input wire logic       cs_n_in,
    input wire logic       dout_out,
    input wire logic       dout_oe_out,
    input wire logic [2:0] mux_sel_out,
    input wire logic       track_out,
    input wire logic       power_up_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_oe_idle: assert property (cs_n_in [*8] |-> !dout_oe_out)
        else $error("data out enabled while deselected");
    a_dout_idle: assert property (cs_n_in [*8] |-> !dout_out)
        else $error("data out not low while deselected");
    a_pwr_idle: assert property (cs_n_in [*8] |-> !power_up_out)
        else $error("converter powered while deselected");
    a_oe_active: assert property (!cs_n_in [*8] |-> dout_oe_out)
        else $error("data out not driven while selected");
    a_track_min: assert property ($rose(track_out) |-> track_out [*8])
        else $error("track phase too short");
    a_track_max: assert property ($rose(track_out) |-> ##[1:200] !track_out)
        else $error("track phase never ends");
    a_lead_zero: assert property (track_out |-> !dout_out)
        else $error("data out high during track");
    a_rise_oe: assert property ($rose(dout_out) |-> dout_oe_out)
        else $error("data out rises while released");
    a_mux_hold: assert property (track_out && $past(track_out) |-> $stable(mux_sel_out))
        else $error("channel changed during track");
    c_track: cover property ($rose(track_out));
    c_pwr_gap: cover property ($fell(power_up_out) && !cs_n_in);
    c_dout: cover property ($rose(dout_out));
endmodule // acsc_serial_ctrl_chk

bind acsc_serial_ctrl acsc_serial_ctrl_chk acsc_serial_ctrl_chk_i (
    .core_clk_in, .sys_rst_in, .cs_n_in, .dout_out, .dout_oe_out, .mux_sel_out,
    .track_out, .power_up_out
);

// >>> acsc_host_model.sv
// acsc_host_model.sv: serial host and analog comparator beside the block
// assumes tasks are called at a falling core clock edge
module acsc_host_model (
    input  wire logic        core_clk_in,
    input  wire logic        dout_in,
    input  wire logic        track_in,
    input  wire logic [2:0]  mux_sel_in,
    input  wire logic [7:0]  dac_code_in,
    output logic             cs_n_out,
    output logic             sclk_out,
    output logic             din_out,
    output logic             comp_high_out,
    output logic [15:0]      word_out,
    output logic             word_tgl_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] chan_val [0:7];
    logic [7:0] held_q;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        din_out = 1'b0;
        word_out = 16'h0;
        word_tgl_out = 1'b0;
        held_q = 8'h0;
    end
    always @(posedge core_clk_in) if (track_in) held_q <= chan_val[mux_sel_in];
    // input sits mid-code, so the result equals the held value
    assign comp_high_out = held_q >= dac_code_in;
    task automatic frame_open(input bit together);
        cs_n_out = 1'b0;
        if (together) sclk_out = 1'b0;
        repeat (4) @(negedge core_clk_in);
    endtask
    task automatic conv(input logic [7:0] ctrl, input bit fallen, input int rises);
        logic [15:0] w;
        w = 16'h0;
        for (int i = 0; i < rises; i++) begin
            if (!(fallen && i == 0)) sclk_out = 1'b0;
            din_out = (i < 8) ? ctrl[7 - i] : ~din_out;
            repeat (4) @(negedge core_clk_in);
            sclk_out = 1'b1;
            repeat (4) @(negedge core_clk_in);
            w[15 - i] = dout_in;
        end
        if (rises == 16) begin
            word_out = w;
            word_tgl_out = ~word_tgl_out;
        end
    endtask
    task automatic frame_close();
        cs_n_out = 1'b1;
        din_out = ~din_out;
        repeat (10) @(negedge core_clk_in);
    endtask
endmodule // acsc_host_model

// >>> acsc_serial_ctrl_tb_top.sv
// acsc_serial_ctrl_tb_top.sv: self-checking bench for acsc_serial_ctrl
// assumes the host model and the bound port checker
module acsc_serial_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    wire         cs_n, sclk, din, comp_high, dout, dout_oe, track, power_up, word_tgl;
    wire  [2:0]  mux_sel;
    wire  [7:0]  dac_code;
    wire  [7:0]  result;
    wire  [15:0] word;
    logic [16:0] exp_q [$];
    logic [16:0] e;
    logic [2:0]  st_ch;
    int          mismatches = 0;
    int          checked = 0;
    always #2 clk = ~clk;
    acsc_serial_ctrl acsc_serial_ctrl_i (.core_clk_in(clk), .sys_rst_in(rst), .cs_n_in(cs_n),
        .sclk_in(sclk), .din_in(din), .comp_high_in(comp_high), .dout_out(dout),
        .dout_oe_out(dout_oe), .mux_sel_out(mux_sel), .track_out(track),
        .power_up_out(power_up), .dac_code_out(dac_code), .result_out(result));
    acsc_host_model acsc_host_model_i (.core_clk_in(clk), .dout_in(dout), .track_in(track),
        .mux_sel_in(mux_sel), .dac_code_in(dac_code), .cs_n_out(cs_n), .sclk_out(sclk),
        .din_out(din), .comp_high_out(comp_high), .word_out(word), .word_tgl_out(word_tgl));
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // expected word: zeros, result of this conversion, zeros
    task automatic frame(input int n, input logic [2:0] ch, input bit together);
        logic [7:0] ctrl;
        acsc_host_model_i.frame_open(together);
        for (int k = 0; k < n; k++) begin
            ctrl = 8'($urandom);
            ctrl[5:3] = ch + k[2:0];
            exp_q.push_back({1'b0, 4'h0, acsc_host_model_i.chan_val[st_ch], 4'h0});
            st_ch = ctrl[5:3];
            acsc_host_model_i.conv(ctrl, together && k == 0, 16);
        end
        acsc_host_model_i.frame_close();
    endtask
    always @(word_tgl) begin
        if (!rst) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'hx;
            if (e[16] !== 1'b1) begin
                cmp16(word, e[15:0]);
                cmp8(result, e[11:4]);
            end
        end
    end
    initial begin
        void'($urandom(32'h41e2fb52));
        st_ch = 3'h0;
        for (int i = 0; i < 8; i++) acsc_host_model_i.chan_val[i] = 8'($urandom);
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        frame(3, 3'h2, 1'b0);
        $display("test power_up done");
        for (int c = 0; c < 8; c++) frame(1, 3'(c), 1'b0);
        $display("test channels done");
        frame(4, 3'h5, 1'b1);
        $display("test continuous done");
        acsc_host_model_i.frame_open(1'b0);
        acsc_host_model_i.conv(8'hff, 1'b0, 5);
        acsc_host_model_i.frame_close();
        frame(2, 3'h1, 1'b0);
        $display("test short_frame done");
        repeat (20) @(negedge clk);
        test_done();
    end
    initial begin
        repeat (25000) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule // acsc_serial_ctrl_tb_top
